// File: hdl/lpsc_top.sv
// Purpose: lane partner status register bank with AXI4-Lite slave
// Assumes: link-side inputs synchronous to mclk_in
// Notes:   one register per lane, unmapped access answers SLVERR
//
// Our own choice: the AXI4-Lite slave port.
`include "lpsc_map.svh"

module lpsc_top
   import lpsc_pkg::*;
#(
   parameter int NUM_LANES = 4,
   parameter bit IDLE2_EN  = 1'b1
) (
   input  wire logic                     mclk_in,
   input  wire logic                     rst_n_in,
   // link side
   input  wire lpsc_cs_type [NUM_LANES-1:0] cs_fields_in,
   input  wire logic [NUM_LANES-1:0]     cs_valid_in,
   input  wire logic [NUM_LANES-1:0]     cs_err_in,
   input  wire logic [NUM_LANES-1:0]     lane_sync_in,
   output logic [NUM_LANES-1:0]          status1_impl_out,
   output logic                          irq_out,
   // AXI4-Lite slave
   input  wire logic [`LPSC_ADDR_W-1:0]  s_axi_awaddr_in,
   input  wire logic                     s_axi_awvalid_in,
   output logic                          s_axi_awready_out,
   input  wire logic [31:0]              s_axi_wdata_in,
   input  wire logic [3:0]               s_axi_wstrb_in,
   input  wire logic                     s_axi_wvalid_in,
   output logic                          s_axi_wready_out,
   output logic [1:0]                    s_axi_bresp_out,
   output logic                          s_axi_bvalid_out,
   input  wire logic                     s_axi_bready_in,
   input  wire logic [`LPSC_ADDR_W-1:0]  s_axi_araddr_in,
   input  wire logic                     s_axi_arvalid_in,
   output logic                          s_axi_arready_out,
   output logic [31:0]                   s_axi_rdata_out,
   output logic [1:0]                    s_axi_rresp_out,
   output logic                          s_axi_rvalid_out,
   input  wire logic                     s_axi_rready_in
);

   localparam int NL = NUM_LANES;

   generate
      if (NUM_LANES < 1 || NUM_LANES > 4) begin : g_bad_lanes
         $error("lpsc_top: NUM_LANES must be 1 to 4");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // address decode helpers

   function automatic logic lane_hit(input logic [`LPSC_ADDR_W-1:0] a,
                                     input int                     n);
      logic [`LPSC_ADDR_W-1:0] base;
      base = `LPSC_LANE0_OFF + `LPSC_LANE_STRIDE * n[`LPSC_ADDR_W-1:0];
      lane_hit = IDLE2_EN && (n < NL) && (a == base);
   endfunction

   function automatic logic any_hit(input logic [`LPSC_ADDR_W-1:0] a);
      logic hit;
      hit = (a == `LPSC_IRQ_STATUS_OFF) || (a == `LPSC_IRQ_MASK_OFF);
      for (int n = 0; n < 4; n++) begin
         hit = hit | lane_hit(a, n);
      end
      any_hit = hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write channel

   logic                    aw_hold;
   logic                    w_hold;
   logic [`LPSC_ADDR_W-1:0] aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    next_aw_hold;
   logic                    next_w_hold;
   logic                    next_bvalid;
   logic                    do_write;

   always_comb begin
      do_write = aw_hold & w_hold & ~s_axi_bvalid_out;
      next_aw_hold = do_write ? 1'b0
                   : (aw_hold | (s_axi_awvalid_in & s_axi_awready_out));
      next_w_hold = do_write ? 1'b0
                  : (w_hold | (s_axi_wvalid_in & s_axi_wready_out));
      next_bvalid = do_write | (s_axi_bvalid_out & ~s_axi_bready_in);
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_hold           <= 1'b0;
         w_hold            <= 1'b0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out  <= 1'b0;
      end else begin
         aw_hold           <= next_aw_hold;
         w_hold            <= next_w_hold;
         s_axi_awready_out <= ~next_aw_hold;
         s_axi_wready_out  <= ~next_w_hold;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= `LPSC_RESP_OKAY;
      end else begin
         s_axi_bvalid_out <= next_bvalid;
         if (do_write) begin
            s_axi_bresp_out <= any_hit(aw_addr) ? `LPSC_RESP_OKAY
                                                : `LPSC_RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel

   logic        ar_take;
   logic        next_rvalid;
   logic [31:0] rd_word;
   logic [31:0] lane_value [NL];
   logic [7:0]  irq_status;
   logic [7:0]  irq_mask;

   always_comb begin
      ar_take = s_axi_arvalid_in & s_axi_arready_out;
      next_rvalid = ar_take | (s_axi_rvalid_out & ~s_axi_rready_in);
      rd_word = `LPSC_WORD_ZERO;
      if (s_axi_araddr_in == `LPSC_IRQ_STATUS_OFF) begin
         rd_word = {24'h00_0000, irq_status};
      end else if (s_axi_araddr_in == `LPSC_IRQ_MASK_OFF) begin
         rd_word = {24'h00_0000, irq_mask};
      end
      for (int n = 0; n < NL; n++) begin
         if (lane_hit(s_axi_araddr_in, n)) begin
            rd_word = lane_value[n];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_rvalid_out  <= 1'b0;
         s_axi_arready_out <= 1'b0;
         s_axi_rdata_out   <= `LPSC_WORD_ZERO;
         s_axi_rresp_out   <= `LPSC_RESP_OKAY;
      end else begin
         s_axi_rvalid_out  <= next_rvalid;
         s_axi_arready_out <= ~next_rvalid;
         if (ar_take) begin
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= any_hit(s_axi_araddr_in) ? `LPSC_RESP_OKAY
                                                        : `LPSC_RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lane registers

   logic [3:0] chg_ev;
   logic [3:0] lost_ev;

   lpsc_lane_if lane_bus [NL] ();

   genvar gi;
   generate
      for (gi = 0; gi < NL; gi++) begin : g_lane
         if (IDLE2_EN) begin : g_on
            assign lane_bus[gi].cs          = cs_fields_in[gi];
            assign lane_bus[gi].cs_valid    = cs_valid_in[gi];
            assign lane_bus[gi].cs_err      = cs_err_in[gi];
            assign lane_bus[gi].lane_sync   = lane_sync_in[gi];
            assign lane_bus[gi].rd_clr      =
               ar_take & lane_hit(s_axi_araddr_in, gi);
            assign lane_bus[gi].wr_clr_rcvd =
               do_write & lane_hit(aw_addr, gi) & w_strb[3]
               & w_data[`LPSC_BIT_RCVD];
            assign lane_value[gi] = lane_bus[gi].value;
            assign chg_ev[gi]     = lane_bus[gi].chg_event;
            assign lost_ev[gi]    = lane_bus[gi].info_lost;

            lpsc_lane_reg u_lane (
               .mclk_in  (mclk_in),
               .rst_n_in (rst_n_in),
               .bus      (lane_bus[gi])
            );
         end else begin : g_off
            assign lane_value[gi] = `LPSC_WORD_ZERO;
            assign chg_ev[gi]     = 1'b0;
            assign lost_ev[gi]    = 1'b0;
         end
      end
      for (gi = NL; gi < 4; gi++) begin : g_pad
         assign chg_ev[gi]  = 1'b0;
         assign lost_ev[gi] = 1'b0;
      end
   endgenerate

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status1_impl_out <= '0;
      end else begin
         status1_impl_out <= {NL{IDLE2_EN}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupts: [3:0] values changed, [7:4] information no longer current

   logic [7:0] irq_events;
   logic [7:0] irq_clr;
   logic [7:0] next_irq_status;

   always_comb begin
      irq_events = {lost_ev, chg_ev};
      irq_clr = '0;
      if (do_write && aw_addr == `LPSC_IRQ_STATUS_OFF && w_strb[0]) begin
         irq_clr = w_data[7:0];
      end
      next_irq_status = irq_events | (irq_status & ~irq_clr);
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_status <= `LPSC_IRQ_RESET;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_mask <= `LPSC_IRQ_RESET;
      end else if (do_write && aw_addr == `LPSC_IRQ_MASK_OFF
                   && w_strb[0]) begin
         irq_mask <= w_data[7:0];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(next_irq_status & irq_mask);
      end
   end

endmodule

// File: inc/lpsc_map.svh
// Purpose: offsets, field positions, reset values of the partner status bank
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, aligned words
// Notes:   definitions only
`ifndef LPSC_MAP_SVH
`define LPSC_MAP_SVH

`define LPSC_ADDR_W          8
`define LPSC_LANE0_OFF       8'h14
`define LPSC_LANE1_OFF       8'h34
`define LPSC_LANE2_OFF       8'h54
`define LPSC_LANE3_OFF       8'h74
`define LPSC_LANE_STRIDE     8'h20
`define LPSC_IRQ_STATUS_OFF  8'h80
`define LPSC_IRQ_MASK_OFF    8'h84

`define LPSC_BIT_RCVD        31
`define LPSC_BIT_INFO        30
`define LPSC_BIT_CHG         29
`define LPSC_BIT_IMPL        28
`define LPSC_BIT_TRAINED     27
`define LPSC_FLD_WIDTH_HI    26
`define LPSC_FLD_WIDTH_LO    24
`define LPSC_FLD_LANE_HI     23
`define LPSC_FLD_LANE_LO     20
`define LPSC_FLD_PRE_HI      19
`define LPSC_FLD_PRE_LO      18
`define LPSC_FLD_POST_HI     17
`define LPSC_FLD_POST_LO     16
`define LPSC_BIT_SCRAMBLE    15
`define LPSC_RSVD_W          15

`define LPSC_RESP_OKAY       2'h0
`define LPSC_RESP_SLVERR     2'h2
`define LPSC_IRQ_RESET       8'h00
`define LPSC_WORD_ZERO       32'h0000_0000

`endif

// File: inc/lpsc_pkg.sv
// Purpose: types shared by the partner status bank
// Assumes: nothing
// Notes:   tap encoding 00 none, 01 min, 10 max, 11 intermediate
package lpsc_pkg;

   typedef enum logic [1:0] {
      LPSC_TAP_NONE = 2'h0,
      LPSC_TAP_MIN  = 2'h1,
      LPSC_TAP_MAX  = 2'h2,
      LPSC_TAP_MID  = 2'h3
   } lpsc_tap_type;

   typedef struct packed {
      logic         trained;
      logic [2:0]   port_width;
      logic [3:0]   lane_num;
      lpsc_tap_type tap_pre;
      lpsc_tap_type tap_post;
      logic         scramble;
   } lpsc_cs_type;

endpackage

// File: inc/lpsc_lane_if.sv
// Purpose: carrier between the bus logic and one lane register
// Assumes: single clock domain
// Notes:   ctrl drives the lane inputs, lane answers with its word
interface lpsc_lane_if;
   import lpsc_pkg::*;

   lpsc_cs_type cs;
   logic        cs_valid;
   logic        cs_err;
   logic        lane_sync;
   logic        rd_clr;
   logic        wr_clr_rcvd;
   logic [31:0] value;
   logic        chg_event;
   logic        info_lost;

   modport lane (
      input  cs,
      input  cs_valid,
      input  cs_err,
      input  lane_sync,
      input  rd_clr,
      input  wr_clr_rcvd,
      output value,
      output chg_event,
      output info_lost
   );

   modport ctrl (
      output cs,
      output cs_valid,
      output cs_err,
      output lane_sync,
      output rd_clr,
      output wr_clr_rcvd,
      input  value,
      input  chg_event,
      input  info_lost
   );
endinterface

// File: hdl/lpsc_lane_reg.sv
// Purpose: one lane partner status register
// Assumes: cs_valid is a one-cycle pulse per received IDLE2 CS field/marker
// Notes:   a hardware set always wins over a software clear
`include "lpsc_map.svh"

module lpsc_lane_reg
   import lpsc_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic rst_n_in,
   lpsc_lane_if.lane bus
);

   lpsc_cs_type fields;
   logic        rcvd;
   logic        info;
   logic        chg;
   logic        chg_event;
   logic        info_lost;

   lpsc_cs_type next_fields;
   logic        next_rcvd;
   logic        next_info;
   logic        next_chg;
   logic        good;
   logic        diff;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      good = bus.cs_valid & ~bus.cs_err;
      next_fields = good ? bus.cs : fields;
      next_rcvd = bus.cs_valid | (rcvd & ~bus.wr_clr_rcvd);
      if (good && bus.lane_sync) begin
         next_info = 1'b1;
      end else if (!bus.lane_sync || (bus.cs_valid && bus.cs_err)) begin
         next_info = 1'b0;
      end else begin
         next_info = info;
      end
      diff = (next_rcvd != rcvd) | (next_info != info)
           | (next_fields != fields);
      next_chg = diff | (chg & ~bus.rd_clr);
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fields <= '0;
      end else begin
         fields <= next_fields;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rcvd <= 1'b0;
         info <= 1'b0;
         chg  <= 1'b0;
      end else begin
         rcvd <= next_rcvd;
         info <= next_info;
         chg  <= next_chg;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chg_event <= 1'b0;
         info_lost <= 1'b0;
      end else begin
         chg_event <= diff;
         info_lost <= info & ~next_info;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read-only fields come only from the link side; writes never reach them
   assign bus.value = {rcvd, info, chg,
                       1'b0,
                       fields.trained,
                       fields.port_width,
                       fields.lane_num,
                       fields.tap_pre,
                       fields.tap_post,
                       fields.scramble,
                       {`LPSC_RSVD_W{1'b0}}};
   assign bus.chg_event = chg_event;
   assign bus.info_lost = info_lost;

endmodule

// File: sim/lpsc_link_partner.sv
// Purpose: link partner model sending IDLE2 control-symbol fields
// Assumes: four lanes, one reception per send call
// Notes:   fields show inverted values between receptions
module lpsc_link_partner
   import lpsc_pkg::*;
(
   input  wire logic         mclk_in,
   output lpsc_cs_type [3:0] cs_fields_out,
   output logic [3:0]        cs_valid_out,
   output logic [3:0]        cs_err_out,
   output logic [3:0]        lane_sync_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_fields_out = '0;
      cs_valid_out  = '0;
      cs_err_out    = '0;
      lane_sync_out = '0;
   end
   // one reception, valid for a single cycle, errored only on request
   task automatic send(input int ln, input logic [12:0] cs, input logic e);
      @(posedge mclk_in);
      cs_fields_out[ln] <= cs;
      cs_valid_out[ln]  <= 1'b1;
      cs_err_out[ln]    <= e;
      @(posedge mclk_in);
      cs_fields_out[ln] <= ~cs;
      cs_valid_out[ln]  <= 1'b0;
      cs_err_out[ln]    <= 1'b0;
   endtask
   task automatic set_sync(input logic [3:0] v);
      @(posedge mclk_in);
      lane_sync_out <= v;
   endtask
endmodule

// File: sim/lpsc_top_assertions.sv
// Purpose: port checks on the partner status bank
// Assumes: single clock mclk_in, reset rst_n_in
// Notes:   bound to every lpsc_top instance
`include "lpsc_map.svh"
module lpsc_top_assertions
   import lpsc_pkg::*;
#(
   parameter int NUM_LANES = 4,
   parameter bit IDLE2_EN  = 1'b1
) (
   input wire logic                    mclk_in,
   input wire logic                    rst_n_in,
   input wire logic [NUM_LANES-1:0]    status1_impl_out,
   input wire logic [NUM_LANES-1:0]    cs_err_in,
   input wire logic                    s_axi_awvalid_in,
   input wire logic                    s_axi_awready_out,
   input wire logic                    s_axi_wvalid_in,
   input wire logic                    s_axi_wready_out,
   input wire logic [1:0]              s_axi_bresp_out,
   input wire logic                    s_axi_bvalid_out,
   input wire logic                    s_axi_bready_in,
   input wire logic [`LPSC_ADDR_W-1:0] s_axi_araddr_in,
   input wire logic                    s_axi_arvalid_in,
   input wire logic                    s_axi_arready_out,
   input wire logic [31:0]             s_axi_rdata_out,
   input wire logic [1:0]              s_axi_rresp_out,
   input wire logic                    s_axi_rvalid_out,
   input wire logic                    s_axi_rready_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ar_hs;
   logic wr_hs;
   logic lane_a;
   logic map_a;
   assign ar_hs  = s_axi_arvalid_in && s_axi_arready_out;
   assign wr_hs  = s_axi_awvalid_in && s_axi_awready_out
                   && s_axi_wvalid_in && s_axi_wready_out;
   assign lane_a = IDLE2_EN && (s_axi_araddr_in & 8'h9f) == 8'h14
                   && 32'(s_axi_araddr_in[6:5]) < NUM_LANES;
   assign map_a  = lane_a || s_axi_araddr_in inside {8'h80, 8'h84};
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_impl_flag: assert property (
      $past(rst_n_in) |-> status1_impl_out == {NUM_LANES{IDLE2_EN}})
      else $error("implemented flags wrong");
   a_rd_latency: assert property (ar_hs |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_wr_latency: assert property (wr_hs |-> ##2 s_axi_bvalid_out)
      else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped");
   a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read accepted while busy");
   a_unmapped_err: assert property (ar_hs && !map_a |=>
      s_axi_rresp_out == `LPSC_RESP_SLVERR && s_axi_rdata_out == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_okay: assert property (
      ar_hs && map_a |=> s_axi_rresp_out == `LPSC_RESP_OKAY)
      else $error("mapped read refused");
   a_rsvd_zero: assert property (ar_hs && lane_a |=>
      s_axi_rdata_out[28] == 1'b0 && s_axi_rdata_out[14:0] == 15'h0)
      else $error("reserved bits not zero");
   c_unmapped: cover property (ar_hs && !map_a);
   c_write: cover property (wr_hs);
   c_err_rx: cover property (|cs_err_in);
   c_resp_stall: cover property (s_axi_bvalid_out && !s_axi_bready_in);
endmodule
bind lpsc_top lpsc_top_assertions #(
   .NUM_LANES (NUM_LANES),
   .IDLE2_EN  (IDLE2_EN)
) lpsc_top_assertions_inst (.*);

// File: sim/lpsc_top_bench.sv
// Purpose: self-checking bench for the lane partner status bank
// Assumes: four lanes, IDLE2 built in, 125 MHz clock
// Notes:   registers reached through AXI4-Lite tasks
module lpsc_top_bench import lpsc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk_in;
   logic              rst_n_in;
   lpsc_cs_type [3:0] cs_fields_in;
   logic [3:0]        cs_valid_in;
   logic [3:0]        cs_err_in;
   logic [3:0]        lane_sync_in;
   logic [3:0]        status1_impl_out;
   logic              irq_out;
   logic [7:0]        s_axi_awaddr_in;
   logic              s_axi_awvalid_in;
   logic              s_axi_awready_out;
   logic [31:0]       s_axi_wdata_in;
   logic [3:0]        s_axi_wstrb_in;
   logic              s_axi_wvalid_in;
   logic              s_axi_wready_out;
   logic [1:0]        s_axi_bresp_out;
   logic              s_axi_bvalid_out;
   logic              s_axi_bready_in;
   logic [7:0]        s_axi_araddr_in;
   logic              s_axi_arvalid_in;
   logic              s_axi_arready_out;
   logic [31:0]       s_axi_rdata_out;
   logic [1:0]        s_axi_rresp_out;
   logic              s_axi_rvalid_out;
   logic              s_axi_rready_in;
   logic [31:0]       rd;
   logic [1:0]        rs;
   int                fail_count;
   int                total_checks;
   lpsc_top lpsc_top_inst (.*);
   lpsc_link_partner lpsc_link_partner_inst (
      .mclk_in       (mclk_in),
      .cs_fields_out (cs_fields_in),
      .cs_valid_out  (cs_valid_in),
      .cs_err_out    (cs_err_in),
      .lane_sync_out (lane_sync_in)
   );
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [12:0] csv(input logic [3:0] n);
      return {n[0], n[2:0] + 3'h1, n, n[1:0], ~n[1:0], ~n[0]};
   endfunction
   function automatic logic [31:0] ew(input logic [2:0] b, logic [12:0] c);
      return {b, 1'b0, c, 15'h0};
   endfunction
   function automatic logic [7:0] la(input int i);
      return 8'h14 + 8'(i * 32);
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // lag holds the response ready low for that many cycles after the handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input int lag = 0);
      @(posedge mclk_in);
      s_axi_awaddr_in  <= a;
      s_axi_wdata_in   <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in  <= 1'b1;
      s_axi_bready_in  <= (lag == 0);
      fork
         begin
            do @(posedge mclk_in); while (s_axi_awready_out !== 1'b1);
            s_axi_awvalid_in <= 1'b0;
         end
         begin
            do @(posedge mclk_in); while (s_axi_wready_out !== 1'b1);
            s_axi_wvalid_in <= 1'b0;
         end
      join
      repeat (lag) @(posedge mclk_in);
      s_axi_bready_in <= 1'b1;
      do @(posedge mclk_in); while (s_axi_bvalid_out !== 1'b1);
      rs = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rdw(input logic [7:0] a, input int lag = 0);
      @(posedge mclk_in);
      s_axi_araddr_in  <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in  <= (lag == 0);
      do @(posedge mclk_in); while (s_axi_arready_out !== 1'b1);
      s_axi_arvalid_in <= 1'b0;
      repeat (lag) @(posedge mclk_in);
      s_axi_rready_in <= 1'b1;
      do @(posedge mclk_in); while (s_axi_rvalid_out !== 1'b1);
      rd = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask
   task automatic rc(input string nm, logic [7:0] a, logic [31:0] e);
      rdw(a);
      chk(nm, rd, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         rc("lane reset", la(i), 32'h0);
      end
      rc("irq status reset", 8'h80, 32'h0);
      rc("irq mask reset", 8'h84, 32'h0);
      chk("implemented", 32'(status1_impl_out), 32'hf);
   endtask
   task automatic t_fields();
      lpsc_link_partner_inst.set_sync(4'hf);
      for (int i = 0; i < 4; i++) begin
         lpsc_link_partner_inst.send(i, csv(4'(i)), 1'b0);
         rc("fields", la(i), ew(3'b111, csv(4'(i))));
         rc("after read", la(i), ew(3'b110, csv(4'(i))));
      end
   endtask
   task automatic t_w1c();
      wr(8'h14, 32'hffff_ffff, 2);
      chk("w1c resp", 32'(rs), 32'h0);
      rc("w1c", 8'h14, ew(3'b011, csv(4'h0)));
   endtask
   task automatic t_err();
      lpsc_link_partner_inst.send(1, csv(4'h5), 1'b1);
      rc("errored rx", 8'h34, ew(3'b101, csv(4'h1)));
      lpsc_link_partner_inst.send(1, csv(4'h6), 1'b0);
      rc("good rx", 8'h34, ew(3'b111, csv(4'h6)));
      lpsc_link_partner_inst.set_sync(4'hd);
      rc("sync lost", 8'h34, ew(3'b101, csv(4'h6)));
      lpsc_link_partner_inst.set_sync(4'hf);
   endtask
   task automatic t_irq();
      wr(8'h80, 32'hff);
      wr(8'h84, 32'h1);
      lpsc_link_partner_inst.send(0, csv(4'h7), 1'b0);
      repeat (3) @(posedge mclk_in);
      chk("irq raised", 32'(irq_out), 32'h1);
      rc("irq status", 8'h80, 32'h1);
      wr(8'h80, 32'h1);
      repeat (2) @(posedge mclk_in);
      chk("irq cleared", 32'(irq_out), 32'h0);
      wr(8'h84, 32'h2);
      lpsc_link_partner_inst.send(0, csv(4'h8), 1'b0);
      repeat (3) @(posedge mclk_in);
      chk("irq masked", 32'(irq_out), 32'h0);
      rc("irq pending", 8'h80, 32'h1);
   endtask
   task automatic t_unmapped();
      rdw(8'h10, 2);
      chk("unmapped rresp", 32'(rs), 32'h2);
      chk("unmapped rdata", rd, 32'h0);
      wr(8'h18, 32'hffff_ffff);
      chk("unmapped bresp", 32'(rs), 32'h2);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end
   initial begin
      rst_n_in         = 1'b0;
      s_axi_awaddr_in  = 8'h0;
      s_axi_awvalid_in = 1'b0;
      s_axi_wdata_in   = 32'h0;
      s_axi_wstrb_in   = 4'hf;
      s_axi_wvalid_in  = 1'b0;
      s_axi_bready_in  = 1'b0;
      s_axi_araddr_in  = 8'h0;
      s_axi_arvalid_in = 1'b0;
      s_axi_rready_in  = 1'b0;
      fail_count       = 0;
      total_checks     = 0;
      repeat (16) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_fields();
      t_w1c();
      t_err();
      t_irq();
      t_unmapped();
      results();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      fail_count++;
      results();
   end
endmodule
